/* File: logic/coproc_decode_pkg.sv */
// Constants, register map and types for the coprocessor instruction decode block
// Overview of operation
// - FP decode enable, three groups disable separately
// - FP returning results nonblocking, others autonomous
// - Force bit makes all FP nonblocking
// - Indexed load/store: base plus offset register
// - Update flag writes effective address to base
// - Size code: byte/half/word/quad/double, 101/110 illegal
// - Primary opcode 31 load/store, low bits 001110
// - Config bit disables load/store decoding
// - Eight user instructions, pass config number
// - Divide offload hands decode and execution over
// - Unrecognised user instructions go to coprocessor
// - Exception request flushes non-autonomous, handler if enabled
// - Save pc/state, vector 0x700, syndrome 12/13
// - Writeback ok at no-return; never flush after
// - Nonblocking: writeback ok two cycles after done
// - Blocking/autonomous: writeback ok with operand valid
// - Load: writeback ok at last load word
// - Store: writeback ok only when enabled, committed
// - Handler starts only with state bit 12 set
// - Config bit 16 is store writeback enable
// - Config bit 24 enables divide offload
package coproc_decode_pkg;
  localparam int UDI_NUM_W = 3;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MSR = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_SAVE_PC = 8'h0c;
  localparam logic [7:0] OFS_SAVE_STATE = 8'h10;
  localparam logic [7:0] OFS_SYNDROME = 8'h14;
  localparam logic [2:0] OFS_UDI_PAGE = 3'h1;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] MSR_RESET = 32'h0000_0000;
  localparam logic [31:0] UDI_CFG_RESET = 32'h0000_0000;
  // Control register and MSR fields
  localparam int CTRL_LDST_DIS = 5;
  localparam int CTRL_UDI_DIS = 6;
  localparam int CTRL_FP_DEC_EN = 8;
  localparam int CTRL_FP_ARITH_DIS = 9;
  localparam int CTRL_FP_CONV_DIS = 10;
  localparam int CTRL_FP_EST_DIS = 11;
  localparam int CTRL_FORCE_FP_NB = 15;
  localparam int CTRL_STORE_WB_EN = 16;
  localparam int CTRL_DIV_OFFLOAD = 24;
  localparam int MSR_AUX_EXC_EN = 12;
  // User instruction config fields
  localparam int UDI_VALID = 31;
  localparam int UDI_PRIM_SEL = 30;
  localparam int UDI_CLASS_LO = 28;
  localparam logic [31:0] EXC_VECTOR = 32'h0000_0700;
  localparam int SYN_FP_BIT = 12;
  localparam int SYN_OTHER_BIT = 13;
  localparam int NATIVE_DIV_CYCLES = 35;
  localparam logic [1:0] NB_WBOK_DELAY = 2'h2;
  // Opcodes
  localparam logic [5:0] OP_UDI0 = 6'h00;
  localparam logic [5:0] OP_UDI4 = 6'h04;
  localparam logic [5:0] OP_X31 = 6'h1f;
  localparam logic [5:0] OP_FP_SINGLE = 6'h3b;
  localparam logic [5:0] OP_FP_DOUBLE = 6'h3f;
  localparam logic [2:0] OP_FP_LDST_HI = 3'h6;
  localparam logic [5:0] LDST_LOW = 6'h0e;
  localparam logic [4:0] XO_FDIV = 5'h12;
  localparam logic [4:0] XO_FSQRT = 5'h16;
  localparam logic [4:0] XO_FRES = 5'h18;
  localparam logic [4:0] XO_FRSQRTE = 5'h1a;
  localparam logic [9:0] XO_FCTIW = 10'h00e;
  localparam logic [9:0] XO_FCTIWZ = 10'h00f;
  localparam logic [9:0] XO_FCTID = 10'h32e;
  localparam logic [9:0] XO_FCTIDZ = 10'h32f;
  localparam logic [9:0] XO_FCFID = 10'h34e;
  localparam logic [9:0] XO_FCMPU = 10'h000;
  localparam logic [9:0] XO_FCMPO = 10'h020;
  localparam logic [9:0] XO_MFFS = 10'h247;
  localparam logic [8:0] XO_DIVW = 9'h1eb;
  localparam logic [8:0] XO_DIVWU = 9'h1cb;
  localparam logic [8:0] XO_DIVD = 9'h1e9;
  localparam logic [8:0] XO_DIVDU = 9'h1c9;
  typedef enum logic [1:0] {CLS_AUTO, CLS_BLOCK, CLS_NONBLOCK} exec_class_t;
  typedef enum logic [2:0] {KIND_NONE, KIND_FP, KIND_LDST, KIND_UDI, KIND_FABRIC, KIND_DIV} instr_kind_t;
  typedef enum logic [2:0] {SZ_BYTE, SZ_HALF, SZ_WORD, SZ_QUAD, SZ_DOUBLE} xfer_size_t;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT_DONE, ST_TAIL, ST_WAIT_MEM} exec_state_t;
endpackage

/* File: logic/udi_match_if.sv */
// Interface between the decoder and one user instruction matcher
interface udi_match_if;
  logic [31:0] word;
  logic [31:0] cfg;
  logic hit;
  modport matcher (input word, input cfg, output hit);
  modport owner (output word, output cfg, input hit);
endinterface

/* File: logic/udi_matcher.sv */
// Compares an instruction word against one user instruction configuration
module udi_matcher
  import coproc_decode_pkg::*;
(
  udi_match_if.matcher m
);
  logic [5:0] want_prim;

  assign want_prim = m.cfg[UDI_PRIM_SEL] ? OP_UDI4 : OP_UDI0;
  assign m.hit = m.cfg[UDI_VALID] && (m.word[31:26] == want_prim) && (m.word[10:0] == m.cfg[10:0]);
endmodule

/* File: logic/coproc_decode.sv */
// Coprocessor instruction decode and execution control with APB registers
//
// The APB register port and the register offsets were decided locally.
module coproc_decode
  import coproc_decode_pkg::*;
#(
  parameter int UDI_COUNT = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  input wire logic [31:0] instr_pc,
  input wire logic [31:0] base_operand_register,
  input wire logic [31:0] offset_operand_register,
  input wire logic host_flush,
  input wire logic load_writeback_stage,
  input wire logic store_commit_wb,
  output logic instr_ready,
  output logic decode_reject,
  output logic operand_valid,
  output logic [31:0] coproc_instr_word,
  output logic udi_hit,
  output logic [UDI_NUM_W-1:0] udi_number,
  output logic [31:0] operand_a,
  output logic [31:0] operand_b,
  output logic [31:0] eff_addr,
  output logic base_update,
  output logic [2:0] xfer_size,
  output logic is_store,
  output logic writeback_ok,
  output logic flush,
  input wire logic coproc_done,
  input wire logic coproc_exception_request,
  output logic exc_take,
  output logic [31:0] exc_vector,
  output logic [31:0] save_restore_pc,
  output logic [31:0] save_restore_state,
  output logic [31:0] exception_syndrome
);
  logic [31:0] ctrl_ff, msr_ff, prdata_ff, rd_val;
  logic [31:0] udi_cfg_ff [UDI_COUNT];
  logic pready_ff, pslverr_ff, rd_hit, setup, wr_en;
  logic [UDI_NUM_W-1:0] reg_idx;
  exec_state_t state_ff, nxt_state;
  instr_kind_t kind_ff, kind;
  exec_class_t cls_ff, cls;
  xfer_size_t size;
  logic [1:0] tail_cnt_ff;
  logic store_ff, wbok_given_ff, accept, cancel, abort;
  logic nxt_wbok, nxt_flush, nxt_exc, nxt_opv, nxt_reject;
  logic ready_ff, reject_ff, opv_ff, wbok_ff, flush_ff, exc_ff, udi_hit_ff, base_upd_ff;
  logic [31:0] word_ff, opa_ff, opb_ff, ea_ff, pc_ff, save_pc_ff, save_state_ff, syndrome_ff, vector_ff;
  logic [UDI_NUM_W-1:0] udi_num_ff, udi_num;
  logic [2:0] size_ff;
  logic [UDI_COUNT-1:0] udi_hits;
  logic [5:0] prim;
  logic [2:0] size_code;
  logic fp_arith, fp_ldst, grp_arith, grp_est, grp_conv, fp_result, is_ldst, is_div, is_udi, size_bad;
  logic [31:0] base_or_zero;

  ////////////////////////////////////////////////////////////////////////////
  // Register bus
  assign setup = psel && !penable && !pready_ff;
  assign wr_en = psel && penable && pready_ff && pwrite && !pslverr_ff;
  assign reg_idx = paddr[4:2];

  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = (paddr[1:0] == 2'h0);
    if (paddr[7:5] == OFS_UDI_PAGE && int'(reg_idx) < UDI_COUNT) begin
      rd_val = udi_cfg_ff[reg_idx];
    end else begin
      case (paddr)
        OFS_CTRL: rd_val = ctrl_ff;
        OFS_MSR: rd_val = msr_ff;
        OFS_STATUS: rd_val = {23'h00_0000, wbok_given_ff, kind_ff, cls_ff, 1'b0, state_ff};
        OFS_SAVE_PC: rd_val = save_pc_ff;
        OFS_SAVE_STATE: rd_val = save_state_ff;
        OFS_SYNDROME: rd_val = syndrome_ff;
        default: rd_hit = 1'b0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= setup;
      pslverr_ff <= setup && !rd_hit;
      if (setup) begin
        prdata_ff <= rd_val;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= CTRL_RESET;
      msr_ff <= MSR_RESET;
      for (int i = 0; i < UDI_COUNT; i++) begin
        udi_cfg_ff[i] <= UDI_CFG_RESET;
      end
    end else if (wr_en) begin
      if (paddr == OFS_CTRL) begin
        ctrl_ff <= pwdata;
      end
      if (paddr == OFS_MSR) begin
        msr_ff <= pwdata;
      end
      if (paddr[7:5] == OFS_UDI_PAGE && int'(reg_idx) < UDI_COUNT) begin
        udi_cfg_ff[reg_idx] <= pwdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // User instruction matchers
  udi_match_if umi [UDI_COUNT] ();
  for (genvar g = 0; g < UDI_COUNT; g++) begin : g_udi
    assign umi[g].word = instr_word;
    assign umi[g].cfg = udi_cfg_ff[g];
    assign udi_hits[g] = umi[g].hit;
    udi_matcher u_match (.m(umi[g]));
  end

  always_comb begin
    udi_num = '0;
    for (int i = UDI_COUNT - 1; i >= 0; i--) begin
      if (udi_hits[i]) begin
        udi_num = UDI_NUM_W'(i);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Instruction decode
  assign prim = instr_word[31:26];
  assign fp_arith = (prim == OP_FP_SINGLE) || (prim == OP_FP_DOUBLE);
  assign fp_ldst = (prim[5:3] == OP_FP_LDST_HI);
  assign grp_arith = fp_arith && (instr_word[5:1] == XO_FDIV || instr_word[5:1] == XO_FSQRT);
  assign grp_est = fp_arith && (instr_word[5:1] == XO_FRES || instr_word[5:1] == XO_FRSQRTE);
  assign grp_conv = (prim == OP_FP_DOUBLE) && (instr_word[10:1] == XO_FCTIW || instr_word[10:1] == XO_FCTIWZ
    || instr_word[10:1] == XO_FCTID || instr_word[10:1] == XO_FCTIDZ || instr_word[10:1] == XO_FCFID);
  assign fp_result = fp_arith && (instr_word[0] || instr_word[10:1] == XO_FCMPU
    || instr_word[10:1] == XO_FCMPO || instr_word[10:1] == XO_MFFS);
  assign is_ldst = (prim == OP_X31) && (instr_word[5:0] == LDST_LOW);
  assign is_div = (prim == OP_X31) && (instr_word[9:1] == XO_DIVW || instr_word[9:1] == XO_DIVWU
    || instr_word[9:1] == XO_DIVD || instr_word[9:1] == XO_DIVDU);
  assign is_udi = ((prim == OP_UDI0) && (instr_word[10:0] != 11'h000)) || (prim == OP_UDI4);
  assign size_code = {instr_word[9], instr_word[7:6]};
  assign base_or_zero = (instr_word[20:16] == 5'h00) ? 32'h0000_0000 : base_operand_register;

  always_comb begin
    size_bad = 1'b0;
    unique case (size_code)
      3'h0: size = SZ_BYTE;
      3'h1: size = SZ_HALF;
      3'h2: size = SZ_WORD;
      3'h3, 3'h7: size = SZ_QUAD;
      3'h4: size = SZ_DOUBLE;
      default: begin
        size = SZ_BYTE;
        size_bad = 1'b1;
      end
    endcase
  end

  always_comb begin
    kind = KIND_NONE;
    cls = CLS_BLOCK;
    if (fp_arith || fp_ldst) begin
      if (ctrl_ff[CTRL_FP_DEC_EN] && !(grp_arith && ctrl_ff[CTRL_FP_ARITH_DIS])
          && !(grp_conv && ctrl_ff[CTRL_FP_CONV_DIS]) && !(grp_est && ctrl_ff[CTRL_FP_EST_DIS])) begin
        kind = KIND_FP;
        cls = (fp_result || ctrl_ff[CTRL_FORCE_FP_NB]) ? CLS_NONBLOCK : CLS_AUTO;
      end
    end else if (is_ldst) begin
      if (!ctrl_ff[CTRL_LDST_DIS] && !ctrl_ff[CTRL_UDI_DIS] && !size_bad) begin
        kind = KIND_LDST;
        cls = CLS_NONBLOCK;
      end
    end else if (is_div) begin
      if (ctrl_ff[CTRL_DIV_OFFLOAD]) begin
        kind = KIND_DIV;
      end
    end else if (is_udi) begin
      if (!ctrl_ff[CTRL_UDI_DIS] && (udi_hits != '0)) begin
        kind = KIND_UDI;
        cls = exec_class_t'(udi_cfg_ff[udi_num][UDI_CLASS_LO+:2]);
      end else begin
        kind = KIND_FABRIC;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Execution control
  assign accept = instr_valid && ready_ff;
  assign abort = coproc_exception_request && (cls_ff != CLS_AUTO);
  assign cancel = abort || (host_flush && cls_ff == CLS_NONBLOCK);

  always_comb begin
    nxt_state = state_ff;
    nxt_wbok = 1'b0;
    nxt_opv = 1'b0;
    nxt_reject = 1'b0;
    unique case (state_ff)
      ST_IDLE: begin
        if (accept && kind == KIND_NONE) begin
          nxt_reject = 1'b1;
        end else if (accept) begin
          nxt_opv = 1'b1;
          nxt_wbok = (kind != KIND_LDST) && (cls != CLS_NONBLOCK);
          nxt_state = (kind == KIND_LDST) ? ST_WAIT_MEM : ST_WAIT_DONE;
        end
      end
      ST_WAIT_DONE: begin
        if (cancel) begin
          nxt_state = ST_IDLE;
        end else if (coproc_done) begin
          nxt_state = (cls_ff == CLS_NONBLOCK) ? ST_TAIL : ST_IDLE;
        end
      end
      ST_TAIL: begin
        if (cancel) begin
          nxt_state = ST_IDLE;
        end else if (tail_cnt_ff == NB_WBOK_DELAY - 2'h2) begin
          nxt_wbok = 1'b1;
          nxt_state = ST_IDLE;
        end
      end
      ST_WAIT_MEM: begin
        if (cancel) begin
          nxt_state = ST_IDLE;
        end else if (store_ff ? store_commit_wb : load_writeback_stage) begin
          nxt_wbok = !store_ff || ctrl_ff[CTRL_STORE_WB_EN];
          nxt_state = ST_IDLE;
        end
      end
    endcase
    nxt_flush = (state_ff != ST_IDLE) && cancel && !wbok_given_ff;
    nxt_exc = (state_ff != ST_IDLE) && abort && msr_ff[MSR_AUX_EXC_EN];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_IDLE;
      tail_cnt_ff <= 2'h0;
      wbok_given_ff <= 1'b0;
      ready_ff <= 1'b0;
      reject_ff <= 1'b0;
      opv_ff <= 1'b0;
      wbok_ff <= 1'b0;
      flush_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      tail_cnt_ff <= (state_ff == ST_TAIL) ? tail_cnt_ff + 2'h1 : 2'h0;
      if (state_ff == ST_IDLE) begin
        wbok_given_ff <= nxt_wbok;
      end else if (nxt_wbok) begin
        wbok_given_ff <= 1'b1;
      end
      ready_ff <= (nxt_state == ST_IDLE);
      reject_ff <= nxt_reject;
      opv_ff <= nxt_opv;
      wbok_ff <= nxt_wbok;
      flush_ff <= nxt_flush;
    end
  end

  // Instruction capture at issue
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      kind_ff <= KIND_NONE;
      cls_ff <= CLS_AUTO;
      store_ff <= 1'b0;
      word_ff <= 32'h0000_0000;
      udi_hit_ff <= 1'b0;
      udi_num_ff <= '0;
      opa_ff <= 32'h0000_0000;
      opb_ff <= 32'h0000_0000;
      ea_ff <= 32'h0000_0000;
      base_upd_ff <= 1'b0;
      size_ff <= 3'h0;
      pc_ff <= 32'h0000_0000;
    end else if (accept && kind != KIND_NONE) begin
      kind_ff <= kind;
      cls_ff <= cls;
      store_ff <= (kind == KIND_LDST) && instr_word[8];
      word_ff <= instr_word;
      udi_hit_ff <= (kind == KIND_UDI);
      udi_num_ff <= udi_num;
      opa_ff <= base_operand_register;
      opb_ff <= offset_operand_register;
      ea_ff <= base_or_zero + offset_operand_register;
      base_upd_ff <= (kind == KIND_LDST) && instr_word[10];
      size_ff <= size;
      pc_ff <= instr_pc;
    end
  end

  // Exception capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exc_ff <= 1'b0;
      vector_ff <= EXC_VECTOR;
      save_pc_ff <= 32'h0000_0000;
      save_state_ff <= 32'h0000_0000;
      syndrome_ff <= 32'h0000_0000;
    end else begin
      exc_ff <= nxt_exc;
      vector_ff <= EXC_VECTOR;
      if (nxt_exc) begin
        save_pc_ff <= pc_ff;
        save_state_ff <= msr_ff;
        syndrome_ff <= 32'h0000_0000;
        syndrome_ff[(kind_ff == KIND_FP) ? SYN_FP_BIT : SYN_OTHER_BIT] <= 1'b1;
      end
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign instr_ready = ready_ff;
  assign decode_reject = reject_ff;
  assign operand_valid = opv_ff;
  assign coproc_instr_word = word_ff;
  assign udi_hit = udi_hit_ff;
  assign udi_number = udi_num_ff;
  assign operand_a = opa_ff;
  assign operand_b = opb_ff;
  assign eff_addr = ea_ff;
  assign base_update = base_upd_ff;
  assign xfer_size = size_ff;
  assign is_store = store_ff;
  assign writeback_ok = wbok_ff;
  assign flush = flush_ff;
  assign exc_take = exc_ff;
  assign exc_vector = vector_ff;
  assign save_restore_pc = save_pc_ff;
  assign save_restore_state = save_state_ff;
  assign exception_syndrome = syndrome_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  sequence s_nb_done;
    state_ff == ST_WAIT_DONE && cls_ff == CLS_NONBLOCK && coproc_done && !cancel;
  endsequence
  sequence s_tail_clean;
    !cancel;
  endsequence

  nb_wbok_delay_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_nb_done ##1 s_tail_clean |=> writeback_ok) else $error("nonblocking writeback ok not two after done");
  blk_wbok_opv_a: assert property (@(posedge pclk) disable iff (!presetn)
    operand_valid && kind_ff != KIND_LDST && cls_ff != CLS_NONBLOCK |-> writeback_ok)
    else $error("blocking writeback ok missing with operand valid");
  no_flush_after_a: assert property (@(posedge pclk) disable iff (!presetn)
    wbok_given_ff && state_ff != ST_IDLE |=> !flush) else $error("flush after writeback ok");
  store_wbok_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    writeback_ok && kind_ff == KIND_LDST && is_store |-> $past(ctrl_ff[CTRL_STORE_WB_EN]))
    else $error("store writeback ok while disabled");
  load_wbok_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == ST_WAIT_MEM && !store_ff && load_writeback_stage && !cancel |=> writeback_ok)
    else $error("load writeback ok missing");
  exc_enable_a: assert property (@(posedge pclk) disable iff (!presetn)
    exc_take |-> $past(msr_ff[MSR_AUX_EXC_EN]) && exc_vector == EXC_VECTOR)
    else $error("exception taken while disabled");
  exc_flush_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff != ST_IDLE && abort && !wbok_given_ff |=> flush ##1 (instr_ready || operand_valid))
    else $error("exception did not flush");
  syndrome_a: assert property (@(posedge pclk) disable iff (!presetn)
    exc_take |-> exception_syndrome[SYN_FP_BIT] == (kind_ff == KIND_FP))
    else $error("syndrome bit wrong");
  ldst_dis_a: assert property (@(posedge pclk) disable iff (!presetn)
    accept && is_ldst && ctrl_ff[CTRL_LDST_DIS] |=> decode_reject && !operand_valid)
    else $error("disabled load store decoded");
  force_nb_a: assert property (@(posedge pclk) disable iff (!presetn)
    operand_valid && kind_ff == KIND_FP && $past(ctrl_ff[CTRL_FORCE_FP_NB]) |-> !writeback_ok)
    else $error("forced nonblocking fp gave early writeback ok");
endmodule

/* File: tb/coproc_partner.sv */
// Behavioural fabric coprocessor answering issued instructions
module coproc_partner
  import coproc_decode_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic operand_valid,
  input wire logic flush,
  input wire logic [31:0] coproc_instr_word,
  input wire logic [3:0] lat,
  input wire logic exc_mode,
  input wire logic exc_clear,
  output logic coproc_done,
  output logic coproc_exception_request
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] cnt_ff;
  logic [31:0] word_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 4'h0;
      word_ff <= 32'h0000_0000;
      coproc_done <= 1'b0;
      coproc_exception_request <= 1'b0;
    end else begin
      coproc_done <= 1'b0;
      if (exc_clear) begin
        coproc_exception_request <= 1'b0;
      end
      if (operand_valid) begin
        word_ff <= coproc_instr_word;
        if (exc_mode) begin
          coproc_exception_request <= 1'b1;
        end else begin
          cnt_ff <= lat;
        end
      end else if (flush) begin
        cnt_ff <= 4'h0;
      end else if (cnt_ff == 4'h1) begin
        cnt_ff <= 4'h0;
        coproc_done <= 1'b1;
      end else if (cnt_ff != 4'h0) begin
        cnt_ff <= cnt_ff - 4'h1;
      end
    end
  end
endmodule

/* File: tb/testbench.sv */
// Self-checking bench for the coprocessor decode block
module testbench
  import coproc_decode_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, instr_word = 0, instr_pc = 0;
  logic [31:0] base_operand_register = 0, offset_operand_register = 0;
  logic instr_valid = 0, host_flush = 0, load_writeback_stage = 0, store_commit_wb = 0;
  logic pready, pslverr, instr_ready, decode_reject, operand_valid, udi_hit, base_update;
  logic is_store, writeback_ok, flush, exc_take, coproc_done, coproc_exception_request;
  logic [UDI_NUM_W-1:0] udi_number;
  logic [2:0] xfer_size;
  logic [31:0] coproc_instr_word, operand_a, operand_b, eff_addr, exc_vector;
  logic [31:0] save_restore_pc, save_restore_state, exception_syndrome, b_v, o_v, pc_v;
  logic [3:0] lat = 4'h3;
  logic exc_mode = 0, exc_clear = 0;
  int failures = 0, cmp_count = 0, cyc = 0, t_ov, t_wb, t_dn, t_rej, t_fl, t_ex, t_mem;

  coproc_decode i_coproc_decode (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .instr_valid, .instr_word, .instr_pc, .base_operand_register,
    .offset_operand_register, .host_flush, .load_writeback_stage, .store_commit_wb, .instr_ready,
    .decode_reject, .operand_valid, .coproc_instr_word, .udi_hit, .udi_number, .operand_a,
    .operand_b, .eff_addr, .base_update, .xfer_size, .is_store, .writeback_ok, .flush,
    .coproc_done, .coproc_exception_request, .exc_take, .exc_vector, .save_restore_pc,
    .save_restore_state, .exception_syndrome);
  coproc_partner i_coproc_partner (.pclk, .presetn, .operand_valid, .flush, .coproc_instr_word,
    .lat, .exc_mode, .exc_clear, .coproc_done, .coproc_exception_request);

  always #2.5 pclk = ~pclk;
  // Event cycle stamps
  always @(posedge pclk) begin
    cyc++;
    if (operand_valid) t_ov = cyc;
    if (writeback_ok) t_wb = cyc;
    if (coproc_done) t_dn = cyc;
    if (decode_reject) t_rej = cyc;
    if (flush) t_fl = cyc;
    if (exc_take) t_ex = cyc;
    if (load_writeback_stage || store_commit_wb) t_mem = cyc;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s exp %h seen %h", n, exp, seen);
    end
  endtask
  task automatic guard(input int k, input int lim);
    if (k >= lim) begin
      failures++;
      $display("BAD wait exp %0d seen %0d", lim - 1, k);
      tally_and_finish();
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int k;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    k = 0;
    do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 20);
    guard(k, 20);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1, a, d, r, e);
  endtask
  task automatic issue(input logic [31:0] w);
    int k;
    {t_ov, t_wb, t_dn, t_rej, t_fl, t_ex, t_mem} = {7{-32'sd1}};
    b_v = $urandom;
    o_v = $urandom;
    pc_v = $urandom & 32'hffff_fffc;
    lat <= 4'($urandom_range(1, 8));
    instr_word <= w;
    instr_pc <= pc_v;
    base_operand_register <= b_v;
    offset_operand_register <= o_v;
    instr_valid <= 1;
    k = 0;
    do begin @(posedge pclk); k++; end while (instr_ready !== 1'b1 && k < 50);
    instr_valid <= 0;
    guard(k, 50);
  endtask
  task automatic fin();
    int k;
    k = 0;
    do begin @(posedge pclk); k++; end while (instr_ready !== 1'b1 && k < 60);
    guard(k, 60);
    repeat (3) @(posedge pclk);
  endtask
  task automatic run(input logic [31:0] c, w, input int m, input logic h, input logic [2:0] n);
    wreg(OFS_CTRL, c);
    issue(w);
    fin();
    if (m == 0) begin
      chk("rejected", t_rej >= 0, 1);
      chk("issued", t_ov, -1);
    end else begin
      chk("udi_hit", udi_hit, h);
      chk("udi_number", udi_number, n);
      chk("word", coproc_instr_word, w);
      chk("wb_delay", m == 1 ? t_wb - t_ov : t_wb - t_dn, m == 2 ? 2 : 0);
    end
  endtask
  function automatic logic [31:0] udi(input logic p4, input logic [10:0] x);
    return {p4 ? OP_UDI4 : OP_UDI0, 15'h0c45, x};
  endfunction
  function automatic logic [31:0] fpa(input logic [5:0] op, input logic [4:0] xo, input logic rc);
    return {op, 15'h0c45, 5'h00, xo, rc};
  endfunction
  function automatic int exp_sz(input logic [2:0] s);
    case (s)
      3'd5, 3'd6: return -1;
      3'd3, 3'd7: return 3;
      default: return int'(s);
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge pclk);
    failures++;
    tally_and_finish();
  end
  initial begin
    logic [31:0] r, fct, dvw;
    logic e;
    logic [2:0] s;
    void'($urandom(1757));
    fct = {OP_FP_DOUBLE, 15'h0c45, XO_FCTIW, 1'b0};
    dvw = {OP_X31, 15'h0c45, 1'b0, XO_DIVW, 1'b0};
    repeat (6) @(posedge pclk);
    presetn <= 1;
    apb(0, OFS_CTRL, 0, r, e);
    chk("ctrl_reset", r, CTRL_RESET);
    apb(0, OFS_MSR, 0, r, e);
    chk("msr_reset", r, MSR_RESET);
    apb(0, 8'h20, 0, r, e);
    chk("udi_cfg_reset", r, UDI_CFG_RESET);
    wreg(OFS_CTRL, 32'h0101_8f60);
    apb(0, OFS_CTRL, 0, r, e);
    chk("ctrl_back", r, 32'h0101_8f60);
    apb(0, 8'h40, 0, r, e);
    chk("unmapped_err", {r[30:0], e}, 1);
    apb(1, 8'h02, 32'hffff_ffff, r, e);
    chk("misaligned_err", e, 1);
    $display("test registers done");
    wreg(8'h20, 32'ha000_0155);
    wreg(8'h24, 32'hd000_06aa);
    run(0, udi(0, 11'h155), 2, 1, 0);
    run(0, udi(1, 11'h6aa), 1, 1, 1);
    run(0, udi(0, 11'h0f0), 1, 0, 0);
    run(32'h100, fpa(OP_FP_DOUBLE, XO_FDIV, 0), 1, 0, 0);
    run(32'h100, fpa(OP_FP_DOUBLE, XO_FDIV, 1), 2, 0, 0);
    run(32'h8100, fpa(OP_FP_DOUBLE, XO_FDIV, 0), 2, 0, 0);
    run(32'h100, fct, 1, 0, 0);
    run(32'h100, fpa(OP_FP_SINGLE, XO_FRES, 0), 1, 0, 0);
    run(32'h0, fpa(OP_FP_DOUBLE, XO_FDIV, 0), 0, 0, 0);
    run(32'h300, fpa(OP_FP_DOUBLE, XO_FDIV, 0), 0, 0, 0);
    run(32'h500, fct, 0, 0, 0);
    run(32'h900, fpa(OP_FP_SINGLE, XO_FRES, 0), 0, 0, 0);
    run(32'h0, dvw, 0, 0, 0);
    run(32'h0100_0000, dvw, 1, 0, 0);
    run(32'h20, {OP_X31, 15'h0c45, 5'b00000, LDST_LOW}, 0, 0, 0);
    run(32'h40, {OP_X31, 15'h0c45, 5'b00100, LDST_LOW}, 0, 0, 0);
    $display("test decode done");
    for (int i = 0; i < 16; i++) begin
      s = 3'(i >> 1);
      wreg(OFS_CTRL, s[0] ? 32'h0001_0000 : 32'h0);
      issue({OP_X31, 15'h0c45, s[1] ^ i[0], s[2], i[0], s[1:0], LDST_LOW});
      repeat (2) @(posedge pclk);
      load_writeback_stage <= !i[0];
      store_commit_wb <= i[0];
      @(posedge pclk);
      load_writeback_stage <= 0;
      store_commit_wb <= 0;
      fin();
      if (exp_sz(s) < 0) begin
        chk("size_illegal", t_ov, -1);
      end else begin
        chk("size", xfer_size, exp_sz(s));
        chk("store", is_store, i[0]);
        chk("eff_addr", eff_addr, b_v + o_v);
        chk("opa", operand_a, b_v);
        chk("opb", operand_b, o_v);
        chk("update", base_update, s[1] ^ i[0]);
        chk("mem_wb", t_wb, (i[0] && !s[0]) ? -1 : t_mem + 1);
      end
    end
    $display("test load_store done");
    wreg(OFS_MSR, 32'h0000_1000);
    exc_mode <= 1;
    for (int i = 0; i < 3; i++) begin
      if (i == 2) wreg(OFS_MSR, 32'h0);
      run(i == 0 ? 32'h100 : 32'h0, i == 0 ? fpa(OP_FP_DOUBLE, XO_FDIV, 1) : udi(0, 11'h155), 3, i > 0, 0);
      chk("flushed", t_fl >= 0, 1);
      chk("no_wb", t_wb, -1);
      chk("taken", t_ex >= 0, i < 2);
      if (i < 2) begin
        chk("syndrome", exception_syndrome[i == 0 ? SYN_FP_BIT : SYN_OTHER_BIT], 1);
        chk("vector", exc_vector, EXC_VECTOR);
        chk("save_pc", save_restore_pc, pc_v);
        chk("save_state", save_restore_state, 32'h0000_1000);
      end
      exc_clear <= 1;
      @(posedge pclk);
      exc_clear <= 0;
      @(posedge pclk);
    end
    exc_mode <= 0;
    $display("test exceptions done");
    tally_and_finish();
  end
endmodule
